// File: design/rsc_pkg.sv
// Purpose: shared constants and types for the reset source control block
// Assumes: one 100 MHz system clock
// Notes: counts are in system clock cycles
package rsc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  // external reset: samples of the synchronised low level that start a reset
  localparam int unsigned EXT_RST_MIN_CYC = 3;
  // length of the internal system reset sequence
  localparam int unsigned SYS_RST_CYC = 16;
  // option bits fetched from non-volatile memory during reset
  localparam int unsigned OPT_WIDTH = 8;
  localparam int unsigned OPT_WATCHDOG_RESET_SELECT_POS = 0;
  // erased value of the option byte: every bit reads 1
  localparam logic [7:0] OPT_ERASED = 8'hFF;
  // width of the sequence counter
  localparam int unsigned CNT_W = 5;

  // one-hot state codes of the reset sequencer
  typedef enum logic [4:0] {
    RSC_ST_POR   = 5'b0_0001,
    RSC_ST_LOAD  = 5'b0_0010,
    RSC_ST_HOLD  = 5'b0_0100,
    RSC_ST_RUN   = 5'b0_1000,
    RSC_ST_BROWN = 5'b1_0000
  } rsc_state_t;
endpackage : rsc_pkg

// File: design/rsc_ext_filter.sv
// Purpose: qualifies the active-low external reset input against the clock
// Assumes: pin input is asynchronous; two flops settle it first
// Notes: emits a level while enough consecutive low samples have been seen
`timescale 1ns/10ps
`default_nettype none
module rsc_ext_filter #(
  parameter int unsigned MIN_CYC = rsc_pkg::EXT_RST_MIN_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pin and result
  input wire logic ext_rst_n,
  output logic ext_hit
);
  // elaboration-time refusal of thresholds the 4-bit counter cannot hold
  if (MIN_CYC < 1 || MIN_CYC > 15) begin : g_bad_min_cyc
    $error("rsc_ext_filter: MIN_CYC out of range");
  end

  typedef struct packed {
    logic s1;
    logic s2;
    logic [3:0] cnt;
    logic hit;
  } rsc_filt_t;

  rsc_filt_t st_q;
  rsc_filt_t st_d;

  // synchroniser then consecutive low-sample counter
  always_comb begin
    st_d = st_q;
    st_d.s1 = ext_rst_n;
    st_d.s2 = st_q.s1;
    if (st_q.s2) begin
      st_d.cnt = 4'h0;
      st_d.hit = 1'b0;
    end else if (st_q.cnt < 4'(MIN_CYC)) begin
      st_d.cnt = st_q.cnt + 4'h1;
    end
    st_d.hit = !st_q.s2 && (st_q.cnt >= 4'(MIN_CYC - 1));
  end

  // state register, pin idle high after reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= '{s1: 1'b1, s2: 1'b1, cnt: 4'h0, hit: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign ext_hit = st_q.hit;
endmodule // rsc_ext_filter
`default_nettype wire

// File: design/rsc_top.sv
// Purpose: reset source control: watchdog response, external reset, status
// Assumes: inputs synchronous to REF_CLK except EXT_RST_N
// Notes: option byte is fetched over a simple request/valid port
//
// Overview of operation
// - In run or halt mode a watchdog time-out starts a system reset when the select bit is 1.
// - The select bit reads 1 when the option memory is erased, so the default is a reset.
// - With the select bit at 0 a time-out raises an interrupt request and no reset.
// - A watchdog-caused system reset sets the watchdog cause flag in the reset status.
// - A low pulse of three clocks may be accepted and one of four or more always is.
// - Recovery from brown-out always goes through a full power-on reset.
// - Every reset reloads the option bits into holding registers before code runs.
`timescale 1ns/10ps
`default_nettype none
module rsc_top #(
  parameter int unsigned SEQ_CYC = rsc_pkg::SYS_RST_CYC
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  // reset sources
  input wire logic EXT_RST_N,
  input wire logic BROWNOUT,
  input wire logic WDT_TIMEOUT,
  input wire logic CPU_HALT,
  input wire logic CPU_STOP,
  // option memory fetch
  output logic OPT_REQ,
  input wire logic OPT_VALID,
  input wire logic [7:0] OPT_DATA,
  // results
  output logic CORE_RST,
  output logic WDT_IRQ,
  output logic [7:0] OPT_HOLD,
  output logic WATCHDOG_CAUSE_FLAG,
  output logic EXT_CAUSE_FLAG,
  output logic POR_CAUSE_FLAG
);
  // elaboration-time refusal of sequence lengths the 5-bit counter cannot hold
  if (SEQ_CYC < 2 || SEQ_CYC > 31) begin : g_bad_seq_cyc
    $error("rsc_top: SEQ_CYC out of range");
  end

  // ----------------------------------------------------------------
  // external reset qualification
  // ----------------------------------------------------------------
  logic ext_hit;

  rsc_ext_filter #(
    .MIN_CYC(rsc_pkg::EXT_RST_MIN_CYC)
  ) u_filt (
    .clk(REF_CLK),
    .rst(SYS_RST),
    .ext_rst_n(EXT_RST_N),
    .ext_hit(ext_hit)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    rsc_pkg::rsc_state_t state;
    logic [rsc_pkg::CNT_W-1:0] cnt;
    logic opt_req;
    logic core_rst;
    logic wdt_irq;
    logic [7:0] opt_hold;
    logic wdt_flag;
    logic ext_flag;
    logic por_flag;
  } rsc_regs_t;

  rsc_regs_t r_q;
  rsc_regs_t r_d;

  // watchdog time-out accepted only in run or halt, not stop
  function automatic logic wdt_active(input logic tmo, input logic stop);
    wdt_active = tmo && !stop;
  endfunction

  logic wdt_sel;
  assign wdt_sel = r_q.opt_hold[rsc_pkg::OPT_WATCHDOG_RESET_SELECT_POS];

  // next-state logic
  always_comb begin
    r_d = r_q;
    r_d.wdt_irq = 1'b0;
    case (r_q.state)
      rsc_pkg::RSC_ST_BROWN: begin
        // stay in reset until supply recovers, then a full power-on reset
        r_d.core_rst = 1'b1;
        if (!BROWNOUT) begin
          r_d.state = rsc_pkg::RSC_ST_POR;
          r_d.cnt = '0;
          r_d.wdt_flag = 1'b0;
          r_d.ext_flag = 1'b0;
          r_d.por_flag = 1'b1;
        end
      end
      rsc_pkg::RSC_ST_POR: begin
        // power-on hold period before the option fetch
        r_d.core_rst = 1'b1;
        if (r_q.cnt == rsc_pkg::CNT_W'(SEQ_CYC - 1)) begin
          r_d.state = rsc_pkg::RSC_ST_LOAD;
          r_d.opt_req = 1'b1;
        end else begin
          r_d.cnt = r_q.cnt + 1'b1;
        end
      end
      rsc_pkg::RSC_ST_LOAD: begin
        // fetch option bits while the core stays in reset
        r_d.core_rst = 1'b1;
        if (OPT_VALID) begin
          r_d.opt_hold = OPT_DATA;
          r_d.opt_req = 1'b0;
          r_d.state = rsc_pkg::RSC_ST_RUN;
          r_d.core_rst = 1'b0;
        end
      end
      rsc_pkg::RSC_ST_HOLD: begin
        // system reset sequence, then option reload
        r_d.core_rst = 1'b1;
        if (r_q.cnt == rsc_pkg::CNT_W'(SEQ_CYC - 1)) begin
          r_d.state = rsc_pkg::RSC_ST_LOAD;
          r_d.opt_req = 1'b1;
        end else begin
          r_d.cnt = r_q.cnt + 1'b1;
        end
      end
      rsc_pkg::RSC_ST_RUN: begin
        if (ext_hit) begin
          r_d.state = rsc_pkg::RSC_ST_HOLD;
          r_d.cnt = '0;
          r_d.core_rst = 1'b1;
          r_d.ext_flag = 1'b1;
          r_d.wdt_flag = 1'b0;
          r_d.por_flag = 1'b0;
        end else if (wdt_active(WDT_TIMEOUT, CPU_STOP) && wdt_sel) begin
          r_d.state = rsc_pkg::RSC_ST_HOLD;
          r_d.cnt = '0;
          r_d.core_rst = 1'b1;
          r_d.wdt_flag = 1'b1;
          r_d.ext_flag = 1'b0;
          r_d.por_flag = 1'b0;
        end else if (wdt_active(WDT_TIMEOUT, CPU_STOP)) begin
          r_d.wdt_irq = 1'b1;
        end
      end
      default: begin
        r_d.state = rsc_pkg::RSC_ST_POR;
        r_d.cnt = '0;
        r_d.core_rst = 1'b1;
      end
    endcase
    // brown-out overrides any state
    if (BROWNOUT) begin
      r_d.state = rsc_pkg::RSC_ST_BROWN;
      r_d.core_rst = 1'b1;
      r_d.opt_req = 1'b0;
      r_d.wdt_irq = 1'b0;
    end
  end

  // register stage; option hold starts at the erased value
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      r_q <= '{state: rsc_pkg::RSC_ST_POR, cnt: '0, opt_req: 1'b0, core_rst: 1'b1,
               wdt_irq: 1'b0, opt_hold: rsc_pkg::OPT_ERASED,
               wdt_flag: 1'b0, ext_flag: 1'b0, por_flag: 1'b1};
    end else begin
      r_q <= r_d;
    end
  end

  // outputs straight from flops
  assign OPT_REQ = r_q.opt_req;
  assign CORE_RST = r_q.core_rst;
  assign WDT_IRQ = r_q.wdt_irq;
  assign OPT_HOLD = r_q.opt_hold;
  assign WATCHDOG_CAUSE_FLAG = r_q.wdt_flag;
  assign EXT_CAUSE_FLAG = r_q.ext_flag;
  assign POR_CAUSE_FLAG = r_q.por_flag;
endmodule // rsc_top
`default_nettype wire

// File: test/rsc_asserts.sv
// Purpose: port checks for the reset source control block
// Assumes: one clock domain, reset SYS_RST active high
// Notes: watchdog checks skip cycles where the pin is low or brown-out is set
`timescale 1ns/10ps
`default_nettype none
module rsc_asserts #(
  parameter int unsigned SEQ_CYC = 16
) (
  // clock, reset and sources
  input wire logic REF_CLK, SYS_RST, EXT_RST_N, BROWNOUT, WDT_TIMEOUT, CPU_HALT, CPU_STOP,
  // option fetch
  input wire logic OPT_REQ, OPT_VALID,
  input wire logic [7:0] OPT_DATA, OPT_HOLD,
  // results
  input wire logic CORE_RST, WDT_IRQ, WATCHDOG_CAUSE_FLAG, EXT_CAUSE_FLAG, POR_CAUSE_FLAG
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  // a time-out seen in run with the pin high and no brown-out
  logic wdt_ev;
  assign wdt_ev = WDT_TIMEOUT && !CPU_STOP && !CORE_RST && EXT_RST_N && !BROWNOUT;
  // pin held low from run, then the reset it must start
  sequence s_pin_low;
    (EXT_RST_N == 1'b0 && !CORE_RST) ##0 !EXT_RST_N[*4];
  endsequence
  sequence s_ext_hit;
    ##[1:4] (CORE_RST && EXT_CAUSE_FLAG);
  endsequence
  property p_wdt_rst; wdt_ev && OPT_HOLD[0] |=> CORE_RST && WATCHDOG_CAUSE_FLAG; endproperty
  a_wdt_rst: assert property (p_wdt_rst) else $error("watchdog reset missing");
  property p_wdt_irq; wdt_ev && !OPT_HOLD[0] |=> WDT_IRQ && !CORE_RST; endproperty
  a_wdt_irq: assert property (p_wdt_irq) else $error("watchdog irq wrong");
  property p_por; $fell(SYS_RST) |-> OPT_HOLD == 8'hFF && POR_CAUSE_FLAG && CORE_RST; endproperty
  a_por: assert property (p_por) else $error("reset values wrong");
  property p_fetch; OPT_REQ && OPT_VALID |=> !OPT_REQ && !CORE_RST && OPT_HOLD == $past(OPT_DATA);
  endproperty
  a_fetch: assert property (p_fetch) else $error("option fetch wrong");
  property p_run; $fell(CORE_RST) |-> $past(OPT_REQ) && $past(OPT_VALID); endproperty
  a_run: assert property (p_run) else $error("run before option load");
  property p_ext; s_pin_low |-> s_ext_hit; endproperty
  a_ext: assert property (p_ext) else $error("pin reset missed");
  property p_brown; BROWNOUT |=> CORE_RST; endproperty
  a_brown: assert property (p_brown) else $error("brown-out not held");
  property p_brown_por; $fell(BROWNOUT) |-> ##[0:2] (POR_CAUSE_FLAG && CORE_RST); endproperty
  a_brown_por: assert property (p_brown_por) else $error("no power-on after brown-out");
endmodule // rsc_asserts
bind rsc_top rsc_asserts #(.SEQ_CYC(SEQ_CYC)) u_chk (.*);
`default_nettype wire

// File: test/rsc_opt_mem.sv
// Purpose: option memory model answering the option fetch
// Assumes: request held until valid is taken
// Notes: lag sets prompt or slow answers; released data is scrambled
`timescale 1ns/10ps
`default_nettype none
module rsc_opt_mem (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // fetch port
  input wire logic req,
  input wire logic [7:0] byte_in,
  input wire logic [3:0] lag,
  output logic valid,
  output logic [7:0] data
);
  logic [3:0] cnt;
  // hold valid and data until taken, then drop valid and invert data
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      valid <= 1'b0;
      data <= 8'h00;
      cnt <= 4'h0;
    end else if (valid && req) begin
      valid <= 1'b0;
      data <= ~data;
      cnt <= 4'h0;
    end else if (req && !valid) begin
      if (cnt == lag) begin
        valid <= 1'b1;
        data <= byte_in;
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule // rsc_opt_mem
`default_nettype wire

// File: test/rsc_tb_top.sv
// Purpose: self-checking bench for the reset source control block
// Assumes: short reset sequence of 4 cycles
// Notes: inputs change on rising edges, outputs read on falling edges
`timescale 1ns/10ps
`default_nettype none
module rsc_tb_top;
  logic clk = 1'b0, rst = 1'b1, pin_n = 1'b1, brown = 1'b0, wdt = 1'b0, halt = 1'b0, stop = 1'b0;
  logic [7:0] opt_byte = 8'hFF;
  logic [3:0] lag = 4'h0;
  logic req, valid, core_rst, irq, wflag, eflag, pflag;
  logic [7:0] data, hold;
  int mismatches = 0, checks_done = 0;
  // 100 MHz clock
  always #5 clk = ~clk;
  rsc_top #(.SEQ_CYC(4)) dut (.REF_CLK(clk), .SYS_RST(rst), .EXT_RST_N(pin_n), .BROWNOUT(brown),
    .WDT_TIMEOUT(wdt), .CPU_HALT(halt), .CPU_STOP(stop), .OPT_REQ(req), .OPT_VALID(valid),
    .OPT_DATA(data), .CORE_RST(core_rst), .WDT_IRQ(irq), .OPT_HOLD(hold),
    .WATCHDOG_CAUSE_FLAG(wflag), .EXT_CAUSE_FLAG(eflag), .POR_CAUSE_FLAG(pflag));
  rsc_opt_mem u_mem (.clk(clk), .rst(rst), .req(req), .byte_in(opt_byte), .lag(lag),
    .valid(valid), .data(data));
  // compare one value
  task check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // wait until the core leaves reset
  task wait_run;
    for (int n = 0; n < 200 && core_rst !== 1'b0; n++) @(negedge clk);
    check(core_rst, 1'b0);
  endtask
  // one-cycle time-out pulse, read on the falling edge after it is taken
  task pulse_wdt;
    @(posedge clk) wdt <= 1'b1;
    @(posedge clk) wdt <= 1'b0;
    @(negedge clk);
  endtask
  task t_por;
    @(negedge clk);
    check(hold, 8'hFF);
    check(pflag, 1'b1);
    wait_run;
    check(hold, 8'hFF);
  endtask
  task t_wdt;
    lag <= 4'h3;
    opt_byte <= 8'hFE;
    pulse_wdt;
    check(core_rst, 1'b1);
    check(wflag, 1'b1);
    wait_run;
    check(hold, 8'hFE);
    @(posedge clk) halt <= 1'b1;
    pulse_wdt;
    check(irq, 1'b1);
    check(core_rst, 1'b0);
    @(negedge clk) check(irq, 1'b0);
    @(posedge clk) stop <= 1'b1;
    pulse_wdt;
    check(irq | core_rst, 1'b0);
    @(posedge clk);
    stop <= 1'b0;
    halt <= 1'b0;
  endtask
  task t_ext;
    opt_byte <= 8'hFF;
    @(posedge clk) pin_n <= 1'b0;
    repeat (4) @(posedge clk);
    pin_n <= 1'b1;
    repeat (4) @(negedge clk);
    check({core_rst, eflag, wflag}, 8'h06);
    wait_run;
    check(hold, 8'hFF);
  endtask
  task t_brown;
    @(posedge clk) brown <= 1'b1;
    repeat (3) @(negedge clk);
    check(core_rst, 1'b1);
    @(posedge clk) brown <= 1'b0;
    wait_run;
    check({pflag, eflag, core_rst}, 8'h04);
  endtask
  // print counts and verdict, then end
  task stop_test;
    $display("mismatches %0d checks %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_por;
    t_wdt;
    t_ext;
    t_brown;
    stop_test;
  end
  // hang guard, about 28 times the expected run of about 710 ns
  initial begin
    #20000;
    mismatches++;
    stop_test;
  end
endmodule // rsc_tb_top
`default_nettype wire
